// ==== dv/adc_cal_dcdc_regs_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_cal_regs.svh"
// Self-checking bench for the calibration and converter register bank.
module adc_cal_dcdc_regs_tb;
   import adc_cal_pkg::*;

   // Clock, reset and enable.
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   // Register bus between the host model and the design.
   logic [7:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [31:0] readdata;
   logic waitrequest;
   // Sample stream and converter controls.
   cal_word_t sample_in = 24'h00_0000;
   logic sample_valid = 1'b0;
   cal_word_t corrected_sample;
   logic corrected_valid;
   logic converter_enable;
   logic [3:0] converter_freq_range;
   // Tallies and scratch read data.
   int err_count = 0;
   int checks = 0;
   logic [31:0] rdata;

   // A 100 ns period clock.
   always #50 mclk = ~mclk;

   adc_cal_dcdc_regs u_adc_cal_dcdc_regs (
      .mclk(mclk), .rst(rst), .ce(ce),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .sample_in(sample_in), .sample_valid(sample_valid),
      .corrected_sample(corrected_sample), .corrected_valid(corrected_valid),
      .converter_enable(converter_enable), .converter_freq_range(converter_freq_range)
   );

   host_model u_host_model (
      .mclk(mclk), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest)
   );

   // Compare one value; case inequality so an unknown never passes.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
      end
   endtask : check

   // Read a register and compare the whole 32-bit word; upper half must be zero.
   task automatic rd_check(input logic [5:0] idx, input reg_word_t exp);
      u_host_model.rd(idx, rdata);
      check(rdata, {16'h0000, exp}, "register read");
   endtask : rd_check

   // Reference checksum over five read views, first word and top bit first.
   function automatic logic [15:0] crc_ref(input logic [79:0] words);
      logic [15:0] c;
      c = `CRC_SEED;
      for (int i = 79; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ words[i]) ? `CRC_POLY : 16'h0000);
      end
      return c;
   endfunction : crc_ref

   // Send one sample and judge the corrected result one cycle later.
   task automatic send(input cal_word_t s, input cal_word_t exp);
      @(posedge mclk);
      sample_in <= s;
      sample_valid <= 1'b1;
      @(posedge mclk);
      sample_valid <= 1'b0;
      // Let the edge's register updates land before looking.
      #1;
      check(corrected_valid, 1'b1, "corrected valid");
      check(corrected_sample, exp, "corrected sample");
   endtask : send

   // Reset values at the ports and in every register but 14h.
   task automatic t_reset();
      check(converter_enable, 1'b0, "enable at reset");
      check(converter_freq_range, 4'h0, "range at reset");
      check(readdata, 32'h0000_0000, "read data at reset");
      check(corrected_sample, 24'h00_0000, "sample at reset");
      rd_check(6'h15, 16'h0000);
      rd_check(6'h16, 16'h8000);
      rd_check(6'h17, 16'h0000);
      rd_check(6'h31, 16'h0000);
      rd_check(6'h3E, 16'h0000);
      $display("t_reset done");
   endtask : t_reset

   // Offset and gain applied to samples, including both saturation limits.
   task automatic t_samples();
      send(24'h00_0123, 24'h00_0123);
      u_host_model.wr(6'h15, 16'h6400, 4'h3);
      send(24'h00_044C, 24'h00_03E8);
      u_host_model.wr(6'h16, 16'h4000, 4'h3);
      send(24'h00_044C, 24'h00_01F4);
      send(24'hFF_FC7C, 24'hFF_FE0C);
      // Largest gain code sits just below two, so the result floors to 1799.
      u_host_model.wr(6'h16, 16'hFFFF, 4'h3);
      u_host_model.wr(6'h17, 16'hFFFF, 4'h3);
      send(24'h00_03E8, 24'h00_0707);
      send(24'h7F_FFFF, 24'h7F_FFFF);
      send(24'h80_0000, 24'h80_0000);
      // A negative offset of one adds one at unity gain.
      u_host_model.wr(6'h14, 16'hFFFF, 4'h3);
      u_host_model.wr(6'h15, 16'hFF00, 4'h3);
      u_host_model.wr(6'h16, 16'h8000, 4'h3);
      u_host_model.wr(6'h17, 16'h0000, 4'h3);
      send(24'h00_0005, 24'h00_0006);
      // An offset equal to the sample cancels it; a zero gain clears any sample.
      send(24'hFF_FFFF, 24'h00_0000);
      u_host_model.wr(6'h16, 16'h0000, 4'h3);
      send(24'h00_0005, 24'h00_0000);
      $display("t_samples done");
   endtask : t_samples

   // Every frequency range code, the enable bit and reserved bits.
   task automatic t_ctrl();
      reg_word_t v;
      for (int c = 0; c < 16; c++) begin
         v = {4'h0, c[3:0], 7'h00, c[0]};
         u_host_model.wr(6'h31, v, 4'h3);
         @(posedge mclk);
         #1;
         check(converter_freq_range, c[3:0], "range");
         check(converter_enable, c[0], "enable");
         rd_check(6'h31, v);
      end
      u_host_model.wr(6'h31, 16'hA5A5, 4'h3);
      @(posedge mclk);
      #1;
      check(converter_freq_range, 4'h5, "range");
      check(converter_enable, 1'b1, "enable");
      rd_check(6'h31, 16'hA5A5);
      $display("t_ctrl done");
   endtask : t_ctrl

   // Low bytes read zero, byte lanes, an unmapped index and the read-only checksum.
   task automatic t_regs();
      logic [31:0] crc;
      u_host_model.wr(6'h15, 16'hFFFF, 4'h3);
      rd_check(6'h15, 16'hFF00);
      u_host_model.wr(6'h17, 16'hFFFF, 4'h3);
      rd_check(6'h17, 16'hFF00);
      u_host_model.wr(6'h16, 16'h1234, 4'h3);
      rd_check(6'h16, 16'h1234);
      u_host_model.wr(6'h16, 16'hAAAA, 4'h1);
      rd_check(6'h16, 16'h12AA);
      u_host_model.wr(6'h20, 16'h5A5A, 4'h3);
      rd_check(6'h20, 16'h0000);
      // Let the checksum walk settle before sampling it.
      repeat (8) @(posedge mclk);
      u_host_model.rd(6'h3E, crc);
      // Views now held: 14h, 15h, 16h, 17h and 31h in walk order.
      check(crc, {16'h0000, crc_ref({16'hFFFF, 16'hFF00, 16'h12AA, 16'hFF00, 16'hA5A5})},
            "checksum value");
      u_host_model.wr(6'h3E, ~crc[15:0], 4'h3);
      repeat (8) @(posedge mclk);
      rd_check(6'h3E, crc[15:0]);
      $display("t_regs done");
   endtask : t_regs

   // A low clock enable freezes the bank; a pending write waits until it returns.
   task automatic t_freeze();
      @(posedge mclk);
      ce <= 1'b0;
      fork
         u_host_model.wr(6'h31, 16'h0300, 4'h3);
         begin
            // While frozen the bank neither answers nor takes the write.
            repeat (5) @(posedge mclk);
            check(waitrequest, 1'b1, "frozen answer");
            check(converter_freq_range, 4'h5, "frozen range");
            ce <= 1'b1;
         end
      join
      rd_check(6'h31, 16'h0300);
      check(converter_freq_range, 4'h3, "range after freeze");
      check(converter_enable, 1'b0, "enable after freeze");
      $display("t_freeze done");
   endtask : t_freeze

   // Print the counts and the verdict, then end the run.
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   // Main sequence: reset for eight cycles, then every scenario.
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_samples();
      t_ctrl();
      t_regs();
      t_freeze();
      stop_test();
   end

   // Watchdog: the scenarios need well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge mclk);
      err_count++;
      stop_test();
   end
endmodule : adc_cal_dcdc_regs_tb
`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Host side of the register bus: an Avalon-MM master whose tasks the bench calls.
module host_model (
   // Clock.
   input wire logic mclk,
   // Avalon-MM master signals.
   output logic [7:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest
);
   import adc_cal_pkg::*;

   // Idle bus at time zero, so the slave never sees an unknown request.
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'h0;
   end

   // Write one register and hold it until waitrequest is sampled low.
   // host writes one register
   task automatic wr(input logic [5:0] idx, input reg_word_t data, input logic [3:0] be);
      @(posedge mclk);
      address <= {idx, 2'b00};
      writedata <= {16'h0000, data};
      byteenable <= be;
      write <= 1'b1;
      // No count is assumed here; only the bench watchdog ends a hung wait.
      do @(posedge mclk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask : wr

   // Read one register; the data is taken at the edge that ends the wait.
   task automatic rd(input logic [5:0] idx, output logic [31:0] data);
      @(posedge mclk);
      address <= {idx, 2'b00};
      read <= 1'b1;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      data = readdata;
      read <= 1'b0;
   endtask : rd
endmodule : host_model
`default_nettype wire

// ==== pkg/adc_cal_pkg.sv ====
package adc_cal_pkg;
   // One sixteen-bit register word.
   typedef logic [15:0] reg_word_t;
   // Register index taken from the word address.
   typedef logic [5:0] reg_index_t;
   // Twenty-four bit calibration word or sample.
   typedef logic [23:0] cal_word_t;
   // Checksum walker states, Gray coded along idle, walk, done.
   typedef enum logic [1:0] {
      CRC_IDLE = 2'b00,
      CRC_WALK = 2'b01,
      CRC_DONE = 2'b11
   } crc_state_t;
endpackage : adc_cal_pkg

// ==== pkg/adc_cal_regs.svh ====
`ifndef ADC_CAL_REGS_SVH
`define ADC_CAL_REGS_SVH

// Register indices; the bus byte address is four times the index.
`define IDX_OFF_HI 6'h14
`define IDX_OFF_LO 6'h15
`define IDX_GAIN_HI 6'h16
`define IDX_GAIN_LO 6'h17
`define IDX_CONV_CTRL 6'h31
`define IDX_CHECKSUM 6'h3E

// Reset values of the stored fields.
`define RST_OFF_HI 16'h0000
`define RST_OFF_LO 8'h00
`define RST_GAIN_HI 16'h8000
`define RST_GAIN_LO 8'h00
`define RST_CTRL 16'h0000
`define RST_CRC 16'h0000

// Field positions.
`define LOW_FIELD_MSB 15
`define LOW_FIELD_LSB 8
`define FREQ_MSB 11
`define FREQ_LSB 8
`define ENABLE_BIT 0

// Checksum walk: polynomial, seed and step of the last word covered.
`define CRC_POLY 16'h1021
`define CRC_SEED 16'hFFFF
`define CRC_LAST_STEP 3'h4

// Gain is a fixed-point factor with this many fraction bits.
`define GAIN_FRAC_BITS 23

`endif

// ==== pkg/cal_coeff_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// Calibration coefficients passed from the register bank to the datapath.
interface cal_coeff_if;
   import adc_cal_pkg::*;
   // Signed offset correction.
   cal_word_t offset;
   // Unsigned gain correction, unity at the midpoint code.
   cal_word_t gain;
   modport src (output offset, output gain);
   modport snk (input offset, input gain);
endinterface : cal_coeff_if
`default_nettype wire

// ==== rtl/adc_cal_dcdc_regs.sv ====
// Operation
// R1: Offset low byte in bits 15:8, signed.
// R2: Gain bits 23:8 at 16h, reset 8000h.
// R3: Gain low byte 15:8; low byte reads zero.
// R4: Gain unsigned, range zero to below two.
// R5: Frequency field 11:8 selects modulator range.
// R6: Sixteen codes descend from fastest band.
// R7: Bit 0 enables converter, reset off.
// R8: Read-only checksum at 3Eh, resets zero.
// R9: Offset subtracted from every sample.
// R10: Every sample multiplied by gain.
// R11: Reset gain pattern is unity gain.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "adc_cal_regs.svh"
module adc_cal_dcdc_regs (
   // Clock, reset and enable.
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave, byte address.
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Sample stream through the calibration path.
   input wire adc_cal_pkg::cal_word_t sample_in,
   input wire logic sample_valid,
   output adc_cal_pkg::cal_word_t corrected_sample,
   output logic corrected_valid,
   // Converter controls.
   output logic converter_enable,
   output logic [3:0] converter_freq_range
);
   import adc_cal_pkg::*;

   // Stored register fields.
   reg_word_t off_hi_ff, nxt_off_hi; // Offset bits 23:8.
   logic [7:0] off_lo_ff, nxt_off_lo; // Offset bits 7:0.
   reg_word_t gain_hi_ff, nxt_gain_hi; // Gain bits 23:8.
   logic [7:0] gain_lo_ff, nxt_gain_lo; // Gain bits 7:0.
   reg_word_t ctrl_ff, nxt_ctrl; // Converter control word.
   reg_word_t crc_ff, nxt_crc; // Published checksum.

   // Bus answer state.
   logic wait_ff, nxt_wait; // Waitrequest, high while idle.
   logic [31:0] rdata_ff, nxt_rdata; // Registered read data.

   // Checksum walker state.
   crc_state_t crc_state_ff, nxt_crc_state; // Walker phase.
   logic [2:0] crc_step_ff, nxt_crc_step; // Word being folded in.
   reg_word_t crc_acc_ff, nxt_crc_acc; // Running remainder.

   // Decoded bus terms.
   logic req; // A request is presented.
   logic commit; // A request completes at this edge.
   reg_index_t idx; // Register index from the word address.
   logic kick; // A writable register was written.

   // Coefficients to the datapath.
   cal_coeff_if coeff ();

   // Returns the read view of one register; unmapped indices read zero.
   function automatic reg_word_t read_word(input reg_index_t ri);
      reg_word_t w;
      w = 16'h0000;
      case (ri)
         `IDX_OFF_HI: w = off_hi_ff;
         // R1: low byte upper half
         `IDX_OFF_LO: w = {off_lo_ff, 8'h00};
         // R2: gain high word
         `IDX_GAIN_HI: w = gain_hi_ff;
         // R3: reserved byte zero
         `IDX_GAIN_LO: w = {gain_lo_ff, 8'h00};
         `IDX_CONV_CTRL: w = ctrl_ff;
         // R8: checksum read back
         `IDX_CHECKSUM: w = crc_ff;
         default: w = 16'h0000;
      endcase
      return w;
   endfunction : read_word

   // Maps a walker step onto the register it covers.
   function automatic reg_index_t walk_index(input logic [2:0] step);
      reg_index_t ri;
      ri = `IDX_OFF_HI;
      case (step)
         3'h0: ri = `IDX_OFF_HI;
         3'h1: ri = `IDX_OFF_LO;
         3'h2: ri = `IDX_GAIN_HI;
         3'h3: ri = `IDX_GAIN_LO;
         default: ri = `IDX_CONV_CTRL;
      endcase
      return ri;
   endfunction : walk_index

   // Folds one sixteen-bit word into the remainder, most significant bit first.
   function automatic reg_word_t crc_fold(input reg_word_t crc, input reg_word_t data);
      reg_word_t c;
      logic fb;
      c = crc;
      for (int i = 15; i >= 0; i--) begin
         fb = c[15] ^ data[i];
         c = {c[14:0], 1'b0};
         if (fb) begin
            c = c ^ `CRC_POLY;
         end
      end
      return c;
   endfunction : crc_fold

   // Merges write data into a register word by byte lane.
   function automatic reg_word_t lane_merge(input reg_word_t old, input reg_word_t wd,
                                            input logic [1:0] be);
      reg_word_t m;
      m = old;
      if (be[0]) begin
         m[7:0] = wd[7:0];
      end
      if (be[1]) begin
         m[15:8] = wd[15:8];
      end
      return m;
   endfunction : lane_merge

   // Bus decode. Only the low sixteen data bits reach a register.
   assign req = read || write;
   assign idx = address[7:2];
   assign commit = req && !wait_ff;

   // Answer logic: one wait cycle, then a single cycle with waitrequest low.
   // Read data are captured in the wait cycle so they stand at the answer edge.
   always_comb begin
      nxt_wait = 1'b1;
      nxt_rdata = rdata_ff;
      if (req && wait_ff) begin
         nxt_wait = 1'b0;
         nxt_rdata = {16'h0000, read_word(idx)};
      end
   end

   // Register file next values; a write lands only at the answer edge.
   always_comb begin
      nxt_off_hi = off_hi_ff;
      nxt_off_lo = off_lo_ff;
      nxt_gain_hi = gain_hi_ff;
      nxt_gain_lo = gain_lo_ff;
      nxt_ctrl = ctrl_ff;
      kick = 1'b0;
      if (commit && write) begin
         case (idx)
            `IDX_OFF_HI: begin
               nxt_off_hi = lane_merge(off_hi_ff, writedata[15:0], byteenable[1:0]);
               kick = 1'b1;
            end
            `IDX_OFF_LO: begin
               // R1: store offset low byte
               if (byteenable[1]) begin
                  nxt_off_lo = writedata[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
               end
               kick = 1'b1;
            end
            `IDX_GAIN_HI: begin
               // R2: store gain high
               nxt_gain_hi = lane_merge(gain_hi_ff, writedata[15:0], byteenable[1:0]);
               kick = 1'b1;
            end
            `IDX_GAIN_LO: begin
               // R3: lower byte ignored
               if (byteenable[1]) begin
                  nxt_gain_lo = writedata[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
               end
               kick = 1'b1;
            end
            `IDX_CONV_CTRL: begin
               // R5: store frequency field
               // Reserved bits are kept as written so software sees its own value.
               nxt_ctrl = lane_merge(ctrl_ff, writedata[15:0], byteenable[1:0]);
               kick = 1'b1;
            end
            // The checksum and unmapped words ignore writes.
            default: kick = 1'b0;
         endcase
      end
   end

   // Checksum walker: one register per cycle over the writable words.
   // A fresh write restarts the walk, so the published value never mixes
   // old and new contents; it is refreshed only when a walk completes.
   always_comb begin
      nxt_crc_state = crc_state_ff;
      nxt_crc_step = crc_step_ff;
      nxt_crc_acc = crc_acc_ff;
      nxt_crc = crc_ff;
      case (crc_state_ff)
         CRC_IDLE: begin
            if (kick) begin
               nxt_crc_state = CRC_WALK;
               nxt_crc_step = 3'h0;
               nxt_crc_acc = `CRC_SEED;
            end
         end
         CRC_WALK: begin
            nxt_crc_acc = crc_fold(crc_acc_ff, read_word(walk_index(crc_step_ff)));
            if (crc_step_ff == `CRC_LAST_STEP) begin
               nxt_crc_state = CRC_DONE;
            end else begin
               nxt_crc_step = crc_step_ff + 3'h1;
            end
            if (kick) begin
               nxt_crc_state = CRC_WALK;
               nxt_crc_step = 3'h0;
               nxt_crc_acc = `CRC_SEED;
            end
         end
         CRC_DONE: begin
            // R8: publish computed checksum
            nxt_crc = crc_acc_ff;
            nxt_crc_state = CRC_IDLE;
            if (kick) begin
               nxt_crc_state = CRC_WALK;
               nxt_crc_step = 3'h0;
               nxt_crc_acc = `CRC_SEED;
            end
         end
         default: nxt_crc_state = CRC_IDLE;
      endcase
   end

   // Bus answer registers.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else if (ce) begin
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   // Register file; reset values give unity gain and a disabled converter.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         off_hi_ff <= `RST_OFF_HI;
         off_lo_ff <= `RST_OFF_LO;
         // R11: unity gain reset
         gain_hi_ff <= `RST_GAIN_HI;
         gain_lo_ff <= `RST_GAIN_LO;
         // R7: converter off reset
         ctrl_ff <= `RST_CTRL;
         crc_ff <= `RST_CRC;
      end else if (ce) begin
         off_hi_ff <= nxt_off_hi;
         off_lo_ff <= nxt_off_lo;
         gain_hi_ff <= nxt_gain_hi;
         gain_lo_ff <= nxt_gain_lo;
         ctrl_ff <= nxt_ctrl;
         crc_ff <= nxt_crc;
      end
   end

   // Walker registers.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         crc_state_ff <= CRC_IDLE;
         crc_step_ff <= 3'h0;
         crc_acc_ff <= `CRC_SEED;
      end else if (ce) begin
         crc_state_ff <= nxt_crc_state;
         crc_step_ff <= nxt_crc_step;
         crc_acc_ff <= nxt_crc_acc;
      end
   end

   // Coefficients assembled from the split registers.
   assign coeff.offset = {off_hi_ff, off_lo_ff};
   assign coeff.gain = {gain_hi_ff, gain_lo_ff};

   // Calibration datapath.
   cal_datapath u_datapath (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .coeff(coeff.snk),
      .sample_in(sample_in),
      .sample_valid(sample_valid),
      .corrected_sample(corrected_sample),
      .corrected_valid(corrected_valid)
   );

   // Outputs come straight from their registers.
   assign readdata = rdata_ff;
   assign waitrequest = wait_ff;
   // R7: enable from bit zero
   assign converter_enable = ctrl_ff[`ENABLE_BIT];
   // R6: code passed unchanged
   assign converter_freq_range = ctrl_ff[`FREQ_MSB:`FREQ_LSB];

   default clocking rb_cb @(posedge mclk); endclocking
   default disable iff (rst);

   req_answer_a: assert property (
      (ce && req && waitrequest) |=> !waitrequest)
      else $error("Request was not answered one cycle later.");

   wait_pulse_a: assert property (
      (ce && !waitrequest) |=> waitrequest)
      else $error("Waitrequest stayed low beyond one cycle.");

   off_low_read_a: assert property ( // R1
      (read && !waitrequest && idx == `IDX_OFF_LO)
      |-> readdata == {16'h0000, off_lo_ff, 8'h00})
      else $error("Offset low read lost its byte placement.");

   gain_high_write_a: assert property ( // R2
      (ce && write && !waitrequest && idx == `IDX_GAIN_HI && byteenable[1:0] == 2'b11)
      |=> gain_hi_ff == $past(writedata[15:0]))
      else $error("Gain high write did not land.");

   gain_low_res_a: assert property ( // R3
      (read && !waitrequest && idx == `IDX_GAIN_LO) |-> readdata[7:0] == 8'h00)
      else $error("Reserved gain byte read nonzero.");

   freq_field_a: assert property ( // R5
      (ce && write && !waitrequest && idx == `IDX_CONV_CTRL && byteenable[1])
      |=> converter_freq_range == $past(writedata[11:8]))
      else $error("Frequency field did not follow the write.");

   conv_enable_a: assert property ( // R7
      (ce && write && !waitrequest && idx == `IDX_CONV_CTRL && byteenable[0])
      |=> converter_enable == $past(writedata[0]))
      else $error("Converter enable did not follow the write.");

   crc_readonly_a: assert property ( // R8
      $changed(crc_ff) |-> $past(crc_state_ff) == CRC_DONE)
      else $error("Checksum changed outside walk completion.");

   crc_finish_a: assert property ( // R8
      (ce && kick) ##1 (ce && !kick) [*5] |=> crc_state_ff == CRC_DONE)
      else $error("Checksum walk did not finish in six cycles.");

   read_cov: cover property (read && !waitrequest);
   write_cov: cover property (write && !waitrequest && idx == `IDX_CONV_CTRL);
   crc_cov: cover property (crc_state_ff == CRC_DONE);
endmodule : adc_cal_dcdc_regs
`default_nettype wire

// ==== rtl/cal_datapath.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_cal_regs.svh"
module cal_datapath (
   // Clock, reset and enable.
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Coefficients from the register bank.
   cal_coeff_if.snk coeff,
   // Raw sample stream.
   input wire adc_cal_pkg::cal_word_t sample_in,
   input wire logic sample_valid,
   // Corrected sample stream.
   output adc_cal_pkg::cal_word_t corrected_sample,
   output logic corrected_valid
);
   import adc_cal_pkg::*;

   cal_word_t out_ff, nxt_out; // Registered corrected sample.
   logic valid_ff, nxt_valid; // Registered valid strobe.
   logic signed [24:0] diff; // Offset-corrected sample, one guard bit.
   logic signed [49:0] prod; // Full product before scaling.
   logic signed [26:0] scaled; // Product scaled back by the fraction bits.
   cal_word_t sat; // Saturated result.

   // Correction path: subtract, multiply, scale, then clamp to 24 bits.
   always_comb begin
      // R9: subtract offset first
      diff = $signed({sample_in[23], sample_in}) - $signed({coeff.offset[23], coeff.offset});
      // R10: multiply by gain
      prod = diff * $signed({1'b0, coeff.gain});
      // R4: gain below two
      scaled = prod[49:`GAIN_FRAC_BITS];
      // Clamping keeps a near-two gain from wrapping a full-scale sample.
      if (scaled > $signed(27'sh07F_FFFF)) begin
         sat = 24'h7F_FFFF;
      end else if (scaled < $signed(27'sh780_0000)) begin
         sat = 24'h80_0000;
      end else begin
         sat = scaled[23:0];
      end
      nxt_out = out_ff;
      if (sample_valid) begin
         nxt_out = sat;
      end
      nxt_valid = sample_valid;
   end

   // Output registers; the stage freezes while the clock enable is low.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         out_ff <= 24'h00_0000;
         valid_ff <= 1'b0;
      end else if (ce) begin
         out_ff <= nxt_out;
         valid_ff <= nxt_valid;
      end
   end

   assign corrected_sample = out_ff;
   assign corrected_valid = valid_ff;

   default clocking dp_cb @(posedge mclk); endclocking
   default disable iff (rst);

   unity_gain_a: assert property ( // R11
      (ce && sample_valid && coeff.gain == 24'h80_0000 && coeff.offset == 24'h00_0000)
      |=> (corrected_sample == $past(sample_in) && corrected_valid))
      else $error("Unity gain and zero offset altered the sample.");

   offset_sub_a: assert property ( // R9
      (ce && sample_valid && coeff.gain == 24'h80_0000 && sample_in == coeff.offset)
      |=> corrected_sample == 24'h00_0000)
      else $error("Offset equal to sample did not give zero.");

   zero_gain_a: assert property ( // R10
      (ce && sample_valid && coeff.gain == 24'h00_0000) |=> corrected_sample == 24'h00_0000)
      else $error("Zero gain did not give a zero result.");

   sample_cov: cover property (ce && sample_valid ##1 corrected_valid);
endmodule : cal_datapath
`default_nettype wire
